// ---- asp_pkg.sv ----
// constants, field layout and types for the converter serial host port
package asp_pkg;

	// host frame layout: command, register offset, data byte
	localparam int WORD_W    = 22;
	localparam int CMD_MSB   = 21;
	localparam int CMD_LSB   = 18;
	localparam int ADDR_MSB  = 17;
	localparam int ADDR_LSB  = 8;
	localparam int DATA_MSB  = 7;
	localparam int DATA_LSB  = 0;
	localparam logic [3:0] CMD_WRITE = 4'h1;
	localparam logic [3:0] CMD_READ  = 4'h2;

	// register offsets
	localparam logic [9:0] OFS_INPUT_PROTOCOL  = 10'h008;
	localparam logic [9:0] OFS_OUTPUT_PROTOCOL = 10'h00c;
	localparam logic [9:0] OFS_OUTPUT_WORD     = 10'h010;
	localparam logic [9:0] OFS_PATTERN_LOW     = 10'h014;
	localparam logic [9:0] OFS_PATTERN_MID     = 10'h015;
	localparam logic [9:0] OFS_PATTERN_HIGH    = 10'h016;

	// reset values and writable-bit masks
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] MASK_INPUT     = 8'h03;
	localparam logic [7:0] MASK_OUTPUT    = 8'hdf;
	localparam logic [7:0] MASK_WORD      = 8'h0f;
	localparam logic [7:0] MASK_PAT_HIGH  = 8'h0f;

	// field positions
	localparam int IN_MODE_LSB    = 0;
	localparam int OUT_MODE_LSB   = 0;
	localparam int OUT_LANES_LSB  = 2;
	localparam int OUT_RATE_BIT   = 4;
	localparam int OUT_CLKSEL_LSB = 6;
	localparam int WORD_SRC_BIT   = 0;
	localparam int PARITY_APPEND_ENABLE_BIT     = 1;
	localparam int PSPAN_LSB      = 2;

	// output word
	localparam int SRC_W = 18;

	// internal oscillator runs at half the reference clock
	localparam int CLK_PERIOD_NS = 5;
	localparam int OSC_PERIOD_NS = 10;
	localparam int OSC_HALF_CYC  = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		OMODE_FOLLOW,
		OMODE_EARLY,
		OMODE_INVALID,
		OMODE_SYNC
	} asp_omode_t;

	typedef enum logic [1:0] {
		CSEL_ECHO,
		CSEL_OSC,
		CSEL_OSC_DIV2,
		CSEL_OSC_DIV4
	} asp_csel_t;

	typedef enum logic {
		ST_IDLE,
		ST_FRAME
	} asp_state_t;

endpackage

// ---- asp_tx_if.sv ----
// carrier between frame control and the output lane shifter
`timescale 1ns/1ps
`default_nettype none
interface asp_tx_if;
	logic        load;
	logic [21:0] word;
	logic        shift;
	logic [1:0]  lanes;
	logic [3:0]  sdo;
	modport ctl (output load, output word, output shift, output lanes, input sdo);
	modport shf (input load, input word, input shift, input lanes, output sdo);
endinterface
`default_nettype wire

// ---- asp_lane_shifter.sv ----
// output word shifter driving one, two or four serial lanes
`timescale 1ns/1ps
`default_nettype none
module asp_lane_shifter (
	input  wire logic clk,
	input  wire logic rst_n,
	asp_tx_if.shf     tx
);
	logic [23:0] word_q;
	logic [23:0] word_d;
	logic [3:0]  sdo_q;
	logic [2:0]  nlanes;

	// lane k carries word bits 21-k, 21-k-n, ... msb first
	always_comb begin
		case (tx.lanes)
			2'b10:   nlanes = 3'd2;
			2'b11:   nlanes = 3'd4;
			default: nlanes = 3'd1;
		endcase
		if (tx.load) begin
			word_d = {tx.word, 2'b00};
		end else if (tx.shift) begin
			word_d = word_q << nlanes;
		end else begin
			word_d = word_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			word_q <= 24'h00_0000;
		end else begin
			word_q <= word_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					sdo_q[i] <= 1'b0;
				end else begin
					// unused lanes stay low
					sdo_q[i] <= (3'(i) < nlanes) ? word_d[23 - i] : 1'b0;
				end
			end
		end
	endgenerate

	assign tx.sdo = sdo_q;
endmodule
`default_nettype wire

// ---- asp_serial_port.sv ----
// serial host port of an 18-bit converter: configuration and output word
// Summary of operation
// - input protocol register keeps only bits 1:0; bits 7:2 read as zero.
// - input mode picks clock polarity and phase used to capture host data.
// - output mode 00 drives read data with the input polarity and phase.
// - output mode 01 uses the input protocol but launches each bit early.
// - output mode 11 sends data source-synchronously with its own clock.
// - clock select in mode 11: echo, oscillator, oscillator/2, oscillator/4.
// - data-rate bit ignored outside mode 11; there single or double rate.
// - width field sets lanes: 0x one lane, 10 two, 11 four.
// - output protocol bit 5 is reserved and reads as zero.
// - output frames carry a 22-bit word set by word control, except a frame after a read.
// - word source puts conversion result or fixed pattern in bits 21:4.
// - parity off drives word bits 3 and 2 as zero.
// - parity on drives bit 3 with even parity of bits 21:4.
// - parity on drives bit 2 with even parity of 4/8/12/16 top bits.
// - word control bits 7:4 are reserved and read as zero.
// - pattern low byte holds the eight low pattern bits.
// - all six registers reset to zero.
// - the frame word is decoded and acted on at chip-select rise.
// - pattern completed by a middle byte and a four-bit high register.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        NRST,
	// host serial port
	input  wire logic        CS_N,
	input  wire logic        SCLK,
	input  wire logic        SDI,
	// conversion result
	input  wire logic [17:0] ADC_DATA,
	// serial output lanes and source-synchronous clock
	output logic      [3:0]  SDO,
	output logic             SDO_OE_N,
	output logic             RCLK_OUT,
	output logic             RCLK_OE_N
);
	asp_tx_if tx ();

	// configuration registers
	logic [7:0] in_cfg_q;
	logic [7:0] out_cfg_q;
	logic [7:0] word_cfg_q;
	logic [7:0] pat_low_q;
	logic [7:0] pat_mid_q;
	logic [7:0] pat_high_q;

	// pin history and frame state
	logic               sclk_q;
	logic               cs_q;
	logic [21:0]        rx_q;
	logic               first_q;
	logic               rd_pend_q;
	logic [7:0]         rd_data_q;
	asp_pkg::asp_state_t state_q;

	// source-synchronous clock generation
	logic       burst_q;
	logic       rclk_q;
	logic [2:0] div_q;
	logic [5:0] edges_q;
	logic       sdo_oe_n_q;
	logic       rclk_oe_n_q;

	// decoded fields
	logic                 cpol;
	logic                 cpha;
	asp_pkg::asp_omode_t  omode;
	asp_pkg::asp_csel_t   csel;
	logic                 ddr;
	logic [1:0]           lanes;
	logic                 word_src;
	logic                 parity_append_enable;
	logic [1:0]           pspan;

	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        cap_edge;
	logic        launch_edge;
	logic [3:0]  cmd;
	logic [9:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rd_mux;
	logic [17:0] pattern;
	logic [17:0] src;
	logic        par_full;
	logic        par_part;
	logic [21:0] out_word;
	logic [2:0]  div_half;
	logic        osc_tick;
	logic        sync_edge;
	logic        sync_shift;
	logic        legacy_shift;
	logic [5:0]  beats;
	logic [5:0]  edges_init;

	assign cpol     = in_cfg_q[asp_pkg::IN_MODE_LSB + 1];
	assign cpha     = in_cfg_q[asp_pkg::IN_MODE_LSB];
	assign omode    = asp_pkg::asp_omode_t'(out_cfg_q[asp_pkg::OUT_MODE_LSB +: 2]);
	assign csel     = asp_pkg::asp_csel_t'(out_cfg_q[asp_pkg::OUT_CLKSEL_LSB +: 2]);
	assign ddr      = out_cfg_q[asp_pkg::OUT_RATE_BIT];
	assign lanes    = out_cfg_q[asp_pkg::OUT_LANES_LSB +: 2];
	assign word_src = word_cfg_q[asp_pkg::WORD_SRC_BIT];
	assign parity_append_enable   = word_cfg_q[asp_pkg::PARITY_APPEND_ENABLE_BIT];
	assign pspan    = word_cfg_q[asp_pkg::PSPAN_LSB +: 2];

	// pins are synchronous to REF_CLK, so one history flop finds the edges
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
		end else begin
			sclk_q <= SCLK;
			cs_q   <= CS_N;
		end
	end

	assign cs_fall   = cs_q & ~CS_N;
	assign cs_rise   = ~cs_q & CS_N;
	assign sclk_rise = SCLK & ~sclk_q;
	assign sclk_fall = ~SCLK & sclk_q;
	// phase 0 captures on the first edge of the idle level, phase 1 on the second
	assign cap_edge    = (cpol == cpha) ? sclk_rise : sclk_fall;
	assign launch_edge = (cpol == cpha) ? sclk_fall : sclk_rise;

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			state_q <= asp_pkg::ST_IDLE;
		end else begin
			case (state_q)
				asp_pkg::ST_IDLE: begin
					if (cs_fall) begin
						state_q <= asp_pkg::ST_FRAME;
					end
				end
				asp_pkg::ST_FRAME: begin
					if (cs_rise) begin
						state_q <= asp_pkg::ST_IDLE;
					end
				end
				default: begin
					state_q <= asp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// host word shifts in msb first on each capture edge
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rx_q <= 22'h00_0000;
		end else if (cs_fall) begin
			rx_q <= 22'h00_0000;
		end else if (state_q == asp_pkg::ST_FRAME && !CS_N && cap_edge) begin
			rx_q <= {rx_q[20:0], SDI};
		end
	end

	assign cmd   = rx_q[asp_pkg::CMD_MSB:asp_pkg::CMD_LSB];
	assign addr  = rx_q[asp_pkg::ADDR_MSB:asp_pkg::ADDR_LSB];
	assign wdata = rx_q[asp_pkg::DATA_MSB:asp_pkg::DATA_LSB];

	// writes land only at frame end so a mode change never hits a live frame
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			in_cfg_q   <= asp_pkg::REG_RESET;
			out_cfg_q  <= asp_pkg::REG_RESET;
			word_cfg_q <= asp_pkg::REG_RESET;
			pat_low_q  <= asp_pkg::REG_RESET;
			pat_mid_q  <= asp_pkg::REG_RESET;
			pat_high_q <= asp_pkg::REG_RESET;
		end else if (state_q == asp_pkg::ST_FRAME && cs_rise && cmd == asp_pkg::CMD_WRITE) begin
			case (addr)
				asp_pkg::OFS_INPUT_PROTOCOL: begin
					in_cfg_q <= wdata & asp_pkg::MASK_INPUT;
				end
				asp_pkg::OFS_OUTPUT_PROTOCOL: begin
					// the invalid mode is stored as written; the host avoids it
					out_cfg_q <= wdata & asp_pkg::MASK_OUTPUT;
				end
				asp_pkg::OFS_OUTPUT_WORD: begin
					word_cfg_q <= wdata & asp_pkg::MASK_WORD;
				end
				asp_pkg::OFS_PATTERN_LOW: begin
					pat_low_q <= wdata;
				end
				asp_pkg::OFS_PATTERN_MID: begin
					pat_mid_q <= wdata;
				end
				asp_pkg::OFS_PATTERN_HIGH: begin
					pat_high_q <= wdata & asp_pkg::MASK_PAT_HIGH;
				end
				default: begin
				end
			endcase
		end
	end

	// reserved bits are never stored, so readback shows them as zero
	always_comb begin
		case (addr)
			asp_pkg::OFS_INPUT_PROTOCOL:  rd_mux = in_cfg_q;
			asp_pkg::OFS_OUTPUT_PROTOCOL: rd_mux = out_cfg_q;
			asp_pkg::OFS_OUTPUT_WORD:     rd_mux = word_cfg_q;
			asp_pkg::OFS_PATTERN_LOW:     rd_mux = pat_low_q;
			asp_pkg::OFS_PATTERN_MID:     rd_mux = pat_mid_q;
			asp_pkg::OFS_PATTERN_HIGH:    rd_mux = pat_high_q;
			default:                      rd_mux = 8'h00;
		endcase
	end

	// a read command returns the register in the next frame's top byte
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rd_pend_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else if (state_q == asp_pkg::ST_FRAME && cs_rise) begin
			rd_pend_q <= (cmd == asp_pkg::CMD_READ);
			rd_data_q <= rd_mux;
		end
	end

	// an 18-bit word keeps only the low two bits of the high register
	assign pattern = {pat_high_q[1:0], pat_mid_q, pat_low_q};
	assign src     = word_src ? pattern : ADC_DATA;
	assign par_full = ^src;

	always_comb begin
		case (pspan)
			2'b00:   par_part = ^src[17:14];
			2'b01:   par_part = ^src[17:10];
			2'b10:   par_part = ^src[17:6];
			default: par_part = ^src[17:2];
		endcase
		if (rd_pend_q) begin
			out_word = {rd_data_q, 14'h0000};
		end else if (parity_append_enable) begin
			out_word = {src, par_full, par_part, 2'b00};
		end else begin
			out_word = {src, 4'h0};
		end
	end

	// cpha 1 presents the msb at load, so its first launch edge must not shift
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			first_q <= 1'b0;
		end else if (cs_fall) begin
			first_q <= cpha;
		end else if (!CS_N && launch_edge) begin
			first_q <= 1'b0;
		end
	end

	always_comb begin
		case (omode)
			asp_pkg::OMODE_FOLLOW: legacy_shift = launch_edge & ~first_q;
			asp_pkg::OMODE_EARLY:  legacy_shift = cap_edge;
			default:               legacy_shift = 1'b0;
		endcase
	end

	// source-synchronous clock: echo of SCLK or a divided oscillator
	always_comb begin
		case (csel)
			asp_pkg::CSEL_OSC_DIV2: div_half = 3'(2 * asp_pkg::OSC_HALF_CYC);
			asp_pkg::CSEL_OSC_DIV4: div_half = 3'(4 * asp_pkg::OSC_HALF_CYC);
			default:                div_half = 3'(asp_pkg::OSC_HALF_CYC);
		endcase
		case (lanes)
			2'b10:   beats = 6'd11;
			2'b11:   beats = 6'd6;
			default: beats = 6'd22;
		endcase
		// double rate moves data on every edge, single rate on each full period
		edges_init = ddr ? beats : 6'(2 * beats);
	end

	assign osc_tick  = burst_q && (div_q == div_half - 3'd1);
	assign sync_edge = burst_q && edges_q != 6'd0
		&& ((csel == asp_pkg::CSEL_ECHO) ? (sclk_rise | sclk_fall) : osc_tick);
	// data moves after the falling edge for single rate, after each edge for double
	assign sync_shift = sync_edge && (ddr || rclk_q);

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			div_q <= 3'd0;
		end else if (!burst_q || osc_tick) begin
			div_q <= 3'd0;
		end else begin
			div_q <= div_q + 3'd1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			burst_q <= 1'b0;
			edges_q <= 6'd0;
		end else if (cs_fall && omode == asp_pkg::OMODE_SYNC) begin
			burst_q <= 1'b1;
			edges_q <= edges_init;
		end else if (cs_rise || (sync_edge && edges_q == 6'd1)) begin
			// the clock stops once the word is out, or when the frame ends early
			burst_q <= 1'b0;
			edges_q <= 6'd0;
		end else if (sync_edge) begin
			edges_q <= edges_q - 6'd1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			rclk_q <= 1'b0;
		end else if (!burst_q || cs_rise) begin
			// a cut frame parks the clock low at once, never a last rise
			rclk_q <= 1'b0;
		end else if (sync_edge) begin
			rclk_q <= ~rclk_q;
		end
	end

	// lanes float while the host has this device deselected
	always_ff @(posedge REF_CLK) begin
		if (!NRST) begin
			sdo_oe_n_q  <= 1'b1;
			rclk_oe_n_q <= 1'b1;
		end else begin
			sdo_oe_n_q  <= CS_N;
			rclk_oe_n_q <= CS_N | (omode != asp_pkg::OMODE_SYNC);
		end
	end

	assign tx.load  = cs_fall;
	assign tx.word  = out_word;
	assign tx.lanes = lanes;
	assign tx.shift = !CS_N
		&& ((omode == asp_pkg::OMODE_SYNC) ? sync_shift : legacy_shift);

	asp_lane_shifter u_shifter (
		.clk   (REF_CLK),
		.rst_n (NRST),
		.tx    (tx)
	);

	assign SDO       = tx.sdo;
	assign SDO_OE_N  = sdo_oe_n_q;
	assign RCLK_OUT  = rclk_q;
	assign RCLK_OE_N = rclk_oe_n_q;
endmodule
`default_nettype wire

// ---- asp_serial_port_asserts.sv ----
// concurrent checks on the serial host port outputs
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_chk (
	// clock and reset
	input wire logic       REF_CLK,
	input wire logic       NRST,
	// host lines
	input wire logic       CS_N,
	input wire logic       SCLK,
	// outputs
	input wire logic [3:0] SDO,
	input wire logic       SDO_OE_N,
	input wire logic       RCLK_OUT,
	input wire logic       RCLK_OE_N
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!NRST);

	sequence s_cs_fall;
		$fell(CS_N);
	endsequence
	sequence s_cs_rise;
		$rose(CS_N);
	endsequence
	// three quiet samples, so a burst that ends on chip-select rise is not flagged
	sequence s_idle3;
		RCLK_OE_N [*3];
	endsequence

	property p_reset_out;
		NRST && !$past(NRST) |-> SDO == 4'h0 && SDO_OE_N && !RCLK_OUT && RCLK_OE_N;
	endproperty
	property p_oe_start;
		s_cs_fall |=> !SDO_OE_N;
	endproperty
	property p_oe_release;
		s_cs_rise |=> SDO_OE_N;
	endproperty
	property p_rclk_oe_release;
		s_cs_rise |=> RCLK_OE_N;
	endproperty
	property p_rclk_in_frame;
		!RCLK_OE_N |-> !SDO_OE_N;
	endproperty
	property p_rclk_quiet;
		s_idle3 |-> !RCLK_OUT;
	endproperty
	property p_rclk_rise;
		$rose(RCLK_OUT) |-> !RCLK_OE_N;
	endproperty
	property p_sdo_cause;
		$changed(SDO) && !SDO_OE_N && RCLK_OE_N |->
			$past(SCLK) != $past(SCLK, 2) || ($past(CS_N, 2) && !$past(CS_N));
	endproperty

	a_reset_out: assert property (p_reset_out)
		else $error("outputs not idle after reset");
	a_oe_start: assert property (p_oe_start)
		else $error("lanes not enabled after chip select fall");
	a_oe_release: assert property (p_oe_release)
		else $error("lanes still enabled after chip select rise");
	a_rclk_oe_release: assert property (p_rclk_oe_release)
		else $error("output clock still enabled after frame");
	a_rclk_in_frame: assert property (p_rclk_in_frame)
		else $error("output clock enabled outside a frame");
	a_rclk_quiet: assert property (p_rclk_quiet)
		else $error("output clock high while disabled");
	a_rclk_rise: assert property (p_rclk_rise)
		else $error("output clock rose outside a burst");
	a_sdo_cause: assert property (p_sdo_cause)
		else $error("lane moved without a serial clock edge");
endmodule

bind asp_serial_port asp_serial_port_chk chk_u (
	.REF_CLK  (REF_CLK),
	.NRST     (NRST),
	.CS_N     (CS_N),
	.SCLK     (SCLK),
	.SDO      (SDO),
	.SDO_OE_N (SDO_OE_N),
	.RCLK_OUT (RCLK_OUT),
	.RCLK_OE_N(RCLK_OE_N)
);
`default_nettype wire

// ---- asp_host_model.sv ----
// host controller model: frames words in and captures all four lanes
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
	// clock
	input  wire logic       REF_CLK,
	// serial lines
	input  wire logic [3:0] SDO,
	output var  logic       CS_N,
	output var  logic       SCLK,
	output var  logic       SDI
);
	localparam int PH = 5;
	logic [21:0] cap [4];

	initial begin
		CS_N = 1'b1;
		SCLK = 1'b0;
		SDI  = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask

	// m is the input mode in force; output mode 10 is never requested
	task automatic frame(input logic [21:0] w, input logic [1:0] m);
		@(posedge REF_CLK);
		SCLK <= m[1];
		gap(2);
		CS_N <= 1'b0;
		gap(PH);
		for (int i = 21; i >= 0; i--) begin
			if (m[0])
				SCLK <= ~m[1];
			SDI <= w[i];
			gap(PH);
			for (int k = 0; k < 4; k++)
				cap[k] = {cap[k][20:0], SDO[k]};
			SCLK <= m[1] ~^ m[0];
			gap(PH);
			if (!m[0])
				SCLK <= m[1];
		end
		gap(PH);
		CS_N <= 1'b1;
		// released line shows the inverse so a stale value cannot pass
		SDI <= ~SDI;
		gap(3);
	endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        REF_CLK;
	logic        NRST;
	logic        CS_N;
	logic        SCLK;
	logic        SDI;
	logic [17:0] ADC_DATA;
	logic [3:0]  SDO;
	logic        SDO_OE_N;
	logic        RCLK_OUT;
	logic        RCLK_OE_N;
	logic [1:0]  imode;
	logic        rclk_prev;
	logic [21:0] word;
	int          miscompares;
	int          comparisons;
	int          rises;
	logic [9:0]  ofs_tab [7] = '{10'h008, 10'h00c, 10'h010, 10'h014, 10'h015, 10'h016, 10'h020};
	logic [7:0]  wr_tab [7] = '{8'hfc, 8'he0, 8'hf0, 8'ha5, 8'h5c, 8'hff, 8'hff};
	logic [7:0]  rb_tab [7] = '{8'h00, 8'hc0, 8'h00, 8'ha5, 8'h5c, 8'h0f, 8'h00};
	logic [7:0]  cfg_tab [7] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0b, 8'h0f, 8'h02};
	logic [7:0]  oc_tab [6] = '{8'h04, 8'h08, 8'h0c, 8'h01, 8'h0d, 8'h1c};
	logic [7:0]  sy_tab [6] = '{8'h03, 8'h43, 8'h83, 8'hc3, 8'h5f, 8'h4f};
	int          rn_tab [6] = '{22, 22, 22, 22, 3, 6};

	asp_serial_port dut_u (
		.REF_CLK  (REF_CLK),
		.NRST     (NRST),
		.CS_N     (CS_N),
		.SCLK     (SCLK),
		.SDI      (SDI),
		.ADC_DATA (ADC_DATA),
		.SDO      (SDO),
		.SDO_OE_N (SDO_OE_N),
		.RCLK_OUT (RCLK_OUT),
		.RCLK_OE_N(RCLK_OE_N)
	);
	asp_host_model host_u (
		.REF_CLK(REF_CLK),
		.SDO    (SDO),
		.CS_N   (CS_N),
		.SCLK   (SCLK),
		.SDI    (SDI)
	);

	always #2.5 REF_CLK = ~REF_CLK;

	always @(posedge REF_CLK) begin
		if (RCLK_OUT && !rclk_prev)
			rises++;
		rclk_prev = RCLK_OUT;
	end

	task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] ofs, input logic [7:0] d);
		host_u.frame({asp_pkg::CMD_WRITE, ofs, d}, imode);
	endtask

	// read data comes back in the word of the following frame
	task automatic rd(input logic [9:0] ofs, input logic [7:0] exp);
		host_u.frame({asp_pkg::CMD_READ, ofs, 8'h00}, imode);
		host_u.frame(22'h00_0000, imode);
		check("register", {exp, 14'h0000}, host_u.cap[0]);
	endtask

	task automatic fetch(input int n);
		int idx;
		host_u.frame(22'h00_0000, imode);
		word = '0;
		for (int b = 0; b < 22; b++)
			for (int k = 0; k < n; k++) begin
				idx = 21 - k - n * b;
				if (idx >= 0)
					word[idx] = host_u.cap[k][21 - b];
			end
		word[1:0] = 2'b00;
	endtask

	function automatic logic [21:0] exp_word(input logic [17:0] src, input logic [7:0] cfg);
		logic [17:0] top;
		top = src >> (14 - 4 * cfg[3:2]);
		if (!cfg[1])
			return {src, 4'h0};
		return {src, ^src, ^top, 2'b00};
	endfunction

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge REF_CLK);
		miscompares++;
		conclude();
	end

	initial begin
		REF_CLK = 1'b0;
		NRST = 1'b0;
		ADC_DATA = 18'h2_a5c3;
		imode = 2'b00;
		rclk_prev = 1'b0;
		miscompares = 0;
		comparisons = 0;
		rises = 0;
		repeat (5) @(posedge REF_CLK);
		NRST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		for (int i = 0; i < 7; i++)
			rd(ofs_tab[i], 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(ofs_tab[i], wr_tab[i]);
			rd(ofs_tab[i], rb_tab[i]);
		end
		wr(10'h016, 8'h00);
		for (int m = 1; m < 5; m++) begin
			wr(10'h008, {6'h00, m[1:0]});
			imode = m[1:0];
			wr(10'h014, {4'h3, m[3:0]});
			rd(10'h014, {4'h3, m[3:0]});
		end
		for (int i = 0; i < 7; i++) begin
			wr(10'h010, cfg_tab[i]);
			fetch(1);
			check("word", exp_word(cfg_tab[i][0] ? 18'h0_5c34 : ADC_DATA, cfg_tab[i]), word);
		end
		for (int i = 0; i < 6; i++) begin
			wr(10'h00c, oc_tab[i]);
			fetch(oc_tab[i][3] ? (oc_tab[i][2] ? 4 : 2) : 1);
			check("lanes", exp_word(ADC_DATA, 8'h02), word);
		end
		for (int i = 0; i < 6; i++) begin
			wr(10'h00c, sy_tab[i]);
			rises = 0;
			host_u.frame(22'h00_0000, imode);
			check("clock rises", 22'(rn_tab[i]), 22'(rises));
		end
		NRST <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		NRST <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		rd(10'h00c, 8'h00);
		conclude();
	end
endmodule
`default_nettype wire
